/* core/acs_top.sv */
`timescale 1ns/1ns
module acs_top
  import acs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [7:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  output logic      [7:0]       rdata,
  input  wire logic             timer_trigger_output,
  input  wire logic             external_trigger_pin,
  input  wire acs_conv_rsp_type conv_rsp,
  output acs_conv_req_type      conv_req,
  output logic                  irq
);
  acs_state_type               state_q;
  acs_state_type               state_d;
  logic [ACS_CHAN_W-1:0]       chan_q;
  logic [ACS_CHAN_W-1:0]       chan_d;
  logic [ACS_CHAN_W-1:0]       idx_q;
  logic [ACS_CHAN_W-1:0]       idx_d;
  logic [ACS_CHAN_W-1:0]       channel_select_q;
  logic [ACS_CHAN_W-1:0]       channel_select_lim;
  logic                        on_bit_q;
  logic                        cont_q;
  logic                        scan_q;
  logic                        bufen_q;
  logic                        align_q;
  logic                        diff_q;
  logic                        trg_en_q;
  logic [1:0]                  trg_sel_q;
  logic                        trg_prev_q;
  logic                        pin_sync;
  logic                        trg_src;
  logic                        trg_evt;
  logic [15:0]                 data_q;
  logic [15:0]                 buf_q [ACS_BUF_DEPTH];
  logic [ACS_BUF_DEPTH-1:0]    unread_q;
  logic [15:0]                 aligned;
  acs_conv_req_type            req_d;
  logic [7:0]                  rdata_d;
  logic [ACS_IRQ_N-1:0]        irq_status;
  logic [ACS_IRQ_N-1:0]        irq_mask;
  logic [ACS_IRQ_N-1:0]        irq_set;

  // Address decode
  wire wr_csts  = wr_en && (addr == ACS_ADDR_CSTS);
  wire wr_ctrl1 = wr_en && (addr == ACS_ADDR_CTRL1);
  wire wr_ctrl2 = wr_en && (addr == ACS_ADDR_CTRL2);
  wire wr_ctrl3 = wr_en && (addr == ACS_ADDR_CTRL3);
  wire wr_mask  = wr_en && (addr == ACS_ADDR_MASK);
  wire wr_stat  = wr_en && (addr == ACS_ADDR_STAT);
  wire wr_cfg   = wr_en && (addr == ACS_ADDR_CFG);
  wire buf_hit  = (addr < ACS_BUF_END);
  wire [ACS_CHAN_W-1:0] rd_entry = addr[6:3];
  wire rd_low   = addr[2];
  wire [15:0] rd_word = buf_hit ? buf_q[rd_entry] : ACS_RST_WORD;
  // The byte read second in the documented order marks the entry consumed
  wire rd_consume = rd_en && buf_hit && (rd_low == align_q); // [R5]

  // Software on-bit events
  wire on_set = wr_ctrl1 && wdata[ACS_CTRL1_ON];
  wire on_clr = wr_ctrl1 && !wdata[ACS_CTRL1_ON];

  // Channel select beyond the internal channel is clamped to it
  assign channel_select_lim = (channel_select_q > ACS_INT_CHAN) ? ACS_INT_CHAN // [R1]
                                                                : channel_select_q;

  // Trigger source selection, pin passes a synchroniser first
  acs_sync u_pin_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (external_trigger_pin),
    .sync_out (pin_sync)
  );

  assign trg_src = (trg_sel_q == ACS_TRG_TIMER) ? timer_trigger_output : // [R18]
                   (trg_sel_q == ACS_TRG_PIN)   ? pin_sync : 1'b0;       // [R18]
  assign trg_evt = trg_en_q && trg_src && !trg_prev_q;

  wire go = on_set || trg_evt;

  // Completion classification
  wire done_evt  = (state_q == ACS_WAIT) && conv_rsp.done;
  wire buffered  = scan_q || (cont_q && bufen_q);                     // [R12] [R16]
  wire [ACS_CHAN_W-1:0] buf_sel = scan_q ? chan_q : idx_q;
  wire scan_last = (chan_q == channel_select_lim);
  wire buf_full  = (idx_q == ACS_BUF_LAST);
  wire last      = scan_q ? scan_last : buf_full;
  wire to_data   = done_evt && !buffered;                             // [R11] [R13]
  wire buf_wr    = done_evt && buffered;
  wire cmpl_evt  = done_evt && (!buffered || last);                   // [R12] [R16]
  wire ovr_evt   = buf_wr && unread_q[buf_sel];                       // [R14]

  // Result alignment into a 16-bit word
  assign aligned = align_q ? {conv_rsp.result, 4'h0}                  // [R3] [R4]
                           : {4'h0, conv_rsp.result};                 // [R3] [R4]

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    idx_d   = idx_q;
    case (state_q)
      ACS_OFF: begin
        if (on_set) begin
          state_d = ACS_IDLE; // [R6]
        end
      end
      ACS_IDLE: begin
        if (go) begin
          state_d = ACS_START; // [R7] [R9]
          chan_d  = scan_q ? '0 : channel_select_lim; // [R10] [R15] [R16]
          idx_d   = '0;
        end
      end
      ACS_START: begin
        state_d = ACS_WAIT;
      end
      ACS_WAIT: begin
        if (conv_rsp.done) begin
          if (scan_q && !scan_last) begin
            state_d = ACS_START; // [R15]
            chan_d  = chan_q + 4'h1;
          end else if (cont_q) begin
            state_d = ACS_START; // [R12] [R13] [R17]
            chan_d  = scan_q ? '0 : channel_select_lim; // [R17]
          end else begin
            state_d = ACS_IDLE; // [R7] [R10] [R16]
          end
          if (!scan_q && cont_q && bufen_q) begin
            idx_d = buf_full ? '0 : idx_q + 4'h1; // [R12]
          end
        end
      end
      default: begin
        state_d = ACS_OFF;
      end
    endcase
    if (on_clr) begin
      state_d = ACS_OFF; // [R8]
    end
  end

  // Converter request, registered so every output comes from a flop
  always_comb begin
    req_d.power_on     = (state_d != ACS_OFF); // [R7] [R8]
    req_d.start        = (state_d == ACS_START);
    req_d.channel      = chan_d;
    // Differential never on the internal channel nor while scanning
    req_d.differential = diff_q && !scan_q && (chan_d != ACS_INT_CHAN); // [R2]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ACS_OFF;
      chan_q     <= '0;
      idx_q      <= '0;
      trg_prev_q <= 1'b0;
      conv_req   <= '0;
    end else begin
      state_q    <= state_d;
      chan_q     <= chan_d;
      idx_q      <= idx_d;
      trg_prev_q <= trg_src;
      conv_req   <= req_d;
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_select_q <= '0;
      on_bit_q  <= 1'b0;
      cont_q    <= 1'b0;
      scan_q    <= 1'b0;
      trg_en_q  <= 1'b0;
      trg_sel_q <= ACS_TRG_TIMER;
      bufen_q   <= 1'b0;
      align_q   <= 1'b0;
      diff_q    <= 1'b0;
    end else begin
      if (wr_csts) begin
        channel_select_q <= wdata[ACS_CHAN_W-1:0];
      end
      if (wr_ctrl1) begin
        on_bit_q <= wdata[ACS_CTRL1_ON];
        cont_q   <= wdata[ACS_CTRL1_CONT]; // [R9]
      end
      if (wr_ctrl2) begin
        scan_q    <= wdata[ACS_CTRL2_SCAN]; // [R15]
        trg_en_q  <= wdata[ACS_CTRL2_TEN];
        trg_sel_q <= wdata[ACS_CTRL2_TSEL +: 2]; // [R18]
      end
      if (wr_ctrl3) begin
        bufen_q <= wdata[ACS_CTRL3_BEN]; // [R12] [R13]
      end
      if (wr_cfg) begin
        align_q <= wdata[ACS_CFG_ALIGN]; // [R4]
        diff_q  <= wdata[ACS_CFG_DIFF];
      end
    end
  end

  // Result data register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_q <= ACS_RST_WORD;
    end else if (to_data) begin
      data_q <= aligned; // [R11] [R13]
    end
  end

  // Result buffer entries with their unread marks
  genvar gi;
  generate
    for (gi = 0; gi < ACS_BUF_DEPTH; gi++) begin : g_buf
      wire hit_wr = buf_wr && (buf_sel == ACS_CHAN_W'(gi));
      wire hit_rd = rd_consume && (rd_entry == ACS_CHAN_W'(gi));
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          buf_q[gi]    <= ACS_RST_WORD;
          unread_q[gi] <= 1'b0;
        end else begin
          if (hit_wr) begin
            buf_q[gi] <= aligned; // [R12] [R16]
          end
          // New data beats a same-cycle read so the mark is not lost
          unread_q[gi] <= hit_wr || (unread_q[gi] && !hit_rd); // [R14]
        end
      end
    end
  endgenerate

  // Sticky flags, mask and interrupt line
  assign irq_set[ACS_IRQ_DONE] = cmpl_evt; // [R11] [R12] [R13] [R16]
  assign irq_set[ACS_IRQ_OVR]  = ovr_evt;  // [R14]

  acs_irq u_irq (
    .clk       (clk),
    .nrst      (nrst),
    .set_evt   (irq_set),
    .clr_wr    (wr_stat),
    .clr_data  (wdata[ACS_IRQ_N-1:0]),
    .mask_wr   (wr_mask),
    .mask_data (wdata[ACS_IRQ_N-1:0]),
    .status_q  (irq_status),
    .mask_q    (irq_mask),
    .irq_q     (irq)
  );

  // Read mux, answered the cycle after the strobe
  always_comb begin
    rdata_d = ACS_RST_BYTE;
    if (buf_hit) begin
      rdata_d = rd_low ? rd_word[7:0] : rd_word[15:8];
    end else begin
      case (addr)
        ACS_ADDR_CSTS: begin
          rdata_d                = {4'h0, channel_select_q};
          rdata_d[ACS_CSTS_IE]   = irq_mask[ACS_IRQ_DONE];
          rdata_d[ACS_CSTS_FLAG] = irq_status[ACS_IRQ_DONE];
        end
        ACS_ADDR_CTRL1: begin
          rdata_d[ACS_CTRL1_ON]   = on_bit_q;
          rdata_d[ACS_CTRL1_CONT] = cont_q;
        end
        ACS_ADDR_CTRL2: begin
          rdata_d[ACS_CTRL2_SCAN]      = scan_q;
          rdata_d[ACS_CTRL2_TEN]       = trg_en_q;
          rdata_d[ACS_CTRL2_TSEL +: 2] = trg_sel_q;
        end
        ACS_ADDR_CTRL3: begin
          rdata_d[ACS_CTRL3_BEN] = bufen_q;
          rdata_d[ACS_CTRL3_OVR] = irq_status[ACS_IRQ_OVR];
        end
        ACS_ADDR_DHI: begin
          rdata_d = data_q[15:8];
        end
        ACS_ADDR_DLO: begin
          rdata_d = data_q[7:0];
        end
        ACS_ADDR_MASK: begin
          rdata_d = {6'h00, irq_mask};
        end
        ACS_ADDR_STAT: begin
          rdata_d = {6'h00, irq_status};
        end
        ACS_ADDR_CFG: begin
          rdata_d[ACS_CFG_ALIGN] = align_q;
          rdata_d[ACS_CFG_DIFF]  = diff_q;
        end
        default: begin
          rdata_d = ACS_RST_BYTE;
        end
      endcase
    end
  end

  // Read data holds only in the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= ACS_RST_BYTE;
    end else begin
      rdata <= rd_en ? rdata_d : ACS_RST_BYTE;
    end
  end
endmodule : acs_top

/* core/acs_pkg.sv */
// Overview of operation
// (R1) Results are 12 bits; nine inputs, eight external plus one internal channel.
// (R2) Internal channel is single-ended only; others may run differential. The code keeps every channel single-ended while scanning.
// (R3) Each result is stored left- or right-aligned per the alignment setting.
// (R4) Alignment select 0 means right-aligned, 1 means left-aligned.
// (R5) Software reads high then low byte when left-aligned, low then high when right.
// (R6) First on-bit write wakes the converter only; the second write starts converting.
// (R7) Converter stays powered; each later on-bit write starts exactly one conversion.
// (R8) Software should clear the on-bit when idle; clearing returns to low power.
// (R9) Continuous select 0 is single, 1 is continuous; conversion begins on on-bit.
// (R10) Single non-scan mode converts the selected channel once per start.
// (R11) Non-scan unbuffered result goes to data register, sets flag, interrupts if enabled.
// (R12) Buffered continuous fills the buffer; when full, flag, interrupt, keep converting.
// (R13) Unbuffered continuous: each result to data register, flag, interrupt, auto restart.
// (R14) Overwriting an unread buffer entry sets the overrun flag.
// (R15) Scan enable 1 selects scanning channels zero up to the channel select value.
// (R16) Single scan starts at zero, fills buffer, flags after the last channel.
// (R17) Continuous scan restarts from channel zero after the last channel.
// (R18) Trigger source 00 is the timer trigger output, 01 the external pin.
// (R19) Completion and overrun flags stay set until cleared; enabled flag holds interrupt.
package acs_pkg;
  localparam int          ACS_RES_W      = 12;
  localparam int          ACS_CHAN_W     = 4;
  localparam int          ACS_BUF_DEPTH  = 10;
  localparam int          ACS_IRQ_N      = 2;
  localparam logic [3:0]  ACS_INT_CHAN   = 4'h8;
  localparam logic [3:0]  ACS_BUF_LAST   = 4'h9;
  localparam logic [7:0]  ACS_BUF_END    = 8'h50;
  localparam logic [7:0]  ACS_ADDR_CSTS  = 8'h80;
  localparam logic [7:0]  ACS_ADDR_CTRL1 = 8'h84;
  localparam logic [7:0]  ACS_ADDR_CTRL2 = 8'h88;
  localparam logic [7:0]  ACS_ADDR_CTRL3 = 8'h8C;
  localparam logic [7:0]  ACS_ADDR_DHI   = 8'h90;
  localparam logic [7:0]  ACS_ADDR_DLO   = 8'h94;
  localparam logic [7:0]  ACS_ADDR_MASK  = 8'h98;
  localparam logic [7:0]  ACS_ADDR_STAT  = 8'h9C;
  localparam logic [7:0]  ACS_ADDR_CFG   = 8'hC0;
  localparam int          ACS_CSTS_FLAG  = 7;
  localparam int          ACS_CSTS_IE    = 5;
  localparam int          ACS_CTRL1_ON   = 0;
  localparam int          ACS_CTRL1_CONT = 1;
  localparam int          ACS_CTRL2_SCAN = 1;
  localparam int          ACS_CTRL2_TSEL = 4;
  localparam int          ACS_CTRL2_TEN  = 6;
  localparam int          ACS_CTRL3_OVR  = 6;
  localparam int          ACS_CTRL3_BEN  = 7;
  localparam int          ACS_CFG_DIFF   = 0;
  localparam int          ACS_CFG_ALIGN  = 3;
  localparam int          ACS_IRQ_DONE   = 0;
  localparam int          ACS_IRQ_OVR    = 1;
  localparam logic [1:0]  ACS_TRG_TIMER  = 2'b00;
  localparam logic [1:0]  ACS_TRG_PIN    = 2'b01;
  localparam logic [7:0]  ACS_RST_BYTE   = 8'h00;
  localparam logic [15:0] ACS_RST_WORD   = 16'h0000;

  typedef enum logic [1:0] {
    ACS_OFF   = 2'b00,
    ACS_IDLE  = 2'b01,
    ACS_START = 2'b10,
    ACS_WAIT  = 2'b11
  } acs_state_type;

  typedef struct packed {
    logic                  power_on;
    logic                  start;
    logic                  differential;
    logic [ACS_CHAN_W-1:0] channel;
  } acs_conv_req_type;

  typedef struct packed {
    logic                 done;
    logic [ACS_RES_W-1:0] result;
  } acs_conv_rsp_type;
endpackage : acs_pkg

/* core/acs_sync.sv */
`timescale 1ns/1ns
module acs_sync
  import acs_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : acs_sync

/* core/acs_irq.sv */
`timescale 1ns/1ns
module acs_irq
  import acs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [ACS_IRQ_N-1:0] set_evt,
  input  wire logic                 clr_wr,
  input  wire logic [ACS_IRQ_N-1:0] clr_data,
  input  wire logic                 mask_wr,
  input  wire logic [ACS_IRQ_N-1:0] mask_data,
  output logic      [ACS_IRQ_N-1:0] status_q,
  output logic      [ACS_IRQ_N-1:0] mask_q,
  output logic                      irq_q
);
  logic [ACS_IRQ_N-1:0] clr_bits;
  logic [ACS_IRQ_N-1:0] status_d;

  assign clr_bits = clr_wr ? clr_data : '0;
  // Set beats a same-cycle clear so no event is lost
  assign status_d = (status_q & ~clr_bits) | set_evt; // [R19]

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      if (mask_wr) begin
        mask_q <= mask_data;
      end
      irq_q <= |(status_d & (mask_wr ? mask_data : mask_q)); // [R11] [R19]
    end
  end
endmodule : acs_irq

/* tb/acs_checker.sv */
`timescale 1ns/1ns
module acs_checker
  import acs_pkg::*;
(
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic [7:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic             wr_en,
  input wire acs_conv_rsp_type conv_rsp,
  input wire acs_conv_req_type conv_req,
  input wire logic             irq
);
  logic       busy_q;
  logic       cont_q;
  logic       scan_q;
  logic       mask_q;
  logic       clr_q;
  wire        ctl_wr = wr_en && (addr == ACS_ADDR_CTRL1);
  wire        on_wr  = ctl_wr && wdata[ACS_CTRL1_ON];
  wire        clr_wr = wr_en && (addr == ACS_ADDR_STAT || addr == ACS_ADDR_MASK);
  wire        idle   = conv_req.power_on && !busy_q && !conv_req.start && !conv_rsp.done;
  wire        fin    = busy_q && conv_rsp.done && conv_req.power_on;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Tracks one outstanding conversion; power loss aborts it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cont_q <= 1'b0;
      scan_q <= 1'b0;
      mask_q <= 1'b0;
      clr_q  <= 1'b0;
    end else begin
      busy_q <= conv_req.start || (busy_q && !conv_rsp.done && conv_req.power_on);
      cont_q <= ctl_wr ? wdata[ACS_CTRL1_CONT] : cont_q;
      scan_q <= (wr_en && addr == ACS_ADDR_CTRL2) ? wdata[ACS_CTRL2_SCAN] : scan_q;
      mask_q <= (wr_en && addr == ACS_ADDR_MASK) ? wdata[ACS_IRQ_DONE] : mask_q;
      clr_q  <= clr_wr;
    end
  end

  sequence s_on_idle;
    on_wr && idle;
  endsequence

  a_wake_only: assert property (
    on_wr && !conv_req.power_on |=> conv_req.power_on && !conv_req.start)
    else $error("wake write started a conversion");
  a_on_starts: assert property (
    s_on_idle ##0 !scan_q |=> conv_req.start)
    else $error("on write did not start");
  a_scan_first: assert property (
    s_on_idle ##0 scan_q |=> conv_req.start && conv_req.channel == 4'h0)
    else $error("scan did not begin at channel zero");
  a_off_now: assert property (
    ctl_wr && !wdata[ACS_CTRL1_ON] |=> !conv_req.power_on [*2])
    else $error("off write kept power");
  a_cont_next: assert property (
    fin && cont_q && !ctl_wr |=> conv_req.start)
    else $error("continuous mode did not restart");
  a_done_irq: assert property (
    fin && !cont_q && !scan_q && mask_q && !clr_wr |=> irq)
    else $error("completion gave no interrupt");
  a_irq_holds: assert property (
    irq && !clr_wr && !clr_q |=> irq)
    else $error("interrupt dropped without clear");
  a_int_single: assert property (
    conv_req.start && conv_req.channel == ACS_INT_CHAN |-> !conv_req.differential)
    else $error("internal channel went differential");
  a_chan_range: assert property (
    conv_req.start |-> conv_req.channel <= ACS_INT_CHAN)
    else $error("channel beyond the nine inputs");
endmodule : acs_checker

bind acs_top acs_checker u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .conv_rsp(conv_rsp), .conv_req(conv_req), .irq(irq));

/* tb/acs_core_model.sv */
`timescale 1ns/1ns
module acs_core_model
  import acs_pkg::*;
#(
  parameter int LAT = 6
)
(
  input  wire acs_conv_req_type conv_req,
  input  wire logic             clk,
  input  wire logic             nrst,
  output acs_conv_rsp_type      conv_rsp
);
  int         n_start;
  int         n_done;
  int         cnt;
  logic [3:0] last_ch;
  logic       last_diff;
  logic [3:0] ch_log[$];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_start = 0;
      n_done = 0;
      cnt = 0;
      conv_rsp <= '0;
    end else begin
      if (cnt == 1)
        n_done++;
      // Result bus toggles when not valid so stale data never matches
      conv_rsp <= (cnt == 1) ? {1'b1, last_ch, 8'hC5} : {1'b0, ~conv_rsp.result};
      if (!conv_req.power_on || cnt == 1)
        cnt = 0;
      else if (cnt > 1)
        cnt--;
      if (conv_req.start && conv_req.power_on) begin
        cnt = LAT;
        n_start++;
        last_ch = conv_req.channel;
        last_diff = conv_req.differential;
        ch_log.push_back(conv_req.channel);
      end
    end
  end
endmodule : acs_core_model

/* tb/adc_conversion_sequencer_tb.sv */
`timescale 1ns/1ns
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  logic             clk;
  logic             nrst;
  logic [7:0]       addr;
  logic [7:0]       wdata;
  logic             wr_en;
  logic             rd_en;
  logic [7:0]       rdata;
  logic             tmr;
  logic             pin;
  acs_conv_rsp_type conv_rsp;
  acs_conv_req_type conv_req;
  logic             irq;
  int               n_mismatch;
  int               check_count;
  int               base;
  logic [7:0]       codes[3] = '{8'h40, 8'h50, 8'h60};

  always #4 clk = ~clk;

  acs_top DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .timer_trigger_output(tmr), .external_trigger_pin(pin),
    .conv_rsp(conv_rsp), .conv_req(conv_req), .irq(irq));
  acs_core_model core (.clk(clk), .nrst(nrst), .conv_req(conv_req), .conv_rsp(conv_rsp));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rc

  // Bounded wait on the interrupt or on a count of finished conversions
  task automatic wt(input bit by_irq, input int tgt);
    for (int i = 0; i < 3000; i++) begin
      if (by_irq ? irq === 1'b1 : core.n_done >= tgt)
        break;
      @(posedge clk);
      #1;
    end
    if (by_irq ? irq !== 1'b1 : core.n_done < tgt) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wt

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    tmr = 1'b0;
    pin = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rc(ACS_ADDR_CTRL1, 8'h00);
    rc(8'hF0, 8'h00);
    wr(ACS_ADDR_MASK, 8'h03);
    wr(ACS_ADDR_CSTS, 8'h03);
    wr(ACS_ADDR_CTRL1, 8'h01);
    chk({15'h0, conv_req.power_on}, 16'h0001);
    chk(16'(core.n_start), 16'h0000);
    wr(ACS_ADDR_CTRL1, 8'h01);
    wt(1'b1, 0);
    chk(16'(core.n_start), 16'h0001);
    rc(ACS_ADDR_DLO, 8'hC5);
    rc(ACS_ADDR_DHI, 8'h03);
    rc(ACS_ADDR_STAT, 8'h01);
    rc(ACS_ADDR_CSTS, 8'hA3);
    wr(ACS_ADDR_STAT, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0000);
    wr(ACS_ADDR_CFG, 8'h08);
    wr(ACS_ADDR_CTRL1, 8'h01);
    wt(1'b1, 0);
    chk(16'(core.n_start), 16'h0002);
    rc(ACS_ADDR_DHI, 8'h3C);
    rc(ACS_ADDR_DLO, 8'h50);
    wr(ACS_ADDR_STAT, 8'h03);
    // Channel beyond the last input with differential requested
    wr(ACS_ADDR_CFG, 8'h01);
    wr(ACS_ADDR_CSTS, 8'h09);
    wr(ACS_ADDR_CTRL1, 8'h01);
    wt(1'b1, 0);
    chk({12'h0, core.last_ch}, 16'h0008);
    chk({15'h0, core.last_diff}, 16'h0000);
    wr(ACS_ADDR_STAT, 8'h03);
    // External channel keeps the differential request
    wr(ACS_ADDR_CSTS, 8'h01);
    wr(ACS_ADDR_CTRL1, 8'h01);
    wt(1'b1, 0);
    chk({15'h0, core.last_diff}, 16'h0001);
    chk({12'h0, core.last_ch}, 16'h0001);
    wr(ACS_ADDR_STAT, 8'h03);
    wr(ACS_ADDR_CFG, 8'h00);
    wr(ACS_ADDR_CSTS, 8'h02);
    wr(ACS_ADDR_CTRL2, 8'h02);
    base = core.n_done;
    wr(ACS_ADDR_CTRL1, 8'h01);
    wt(1'b1, 0);
    chk(16'(core.n_done - base), 16'h0003);
    for (int x = 0; x < 3; x++) begin
      rc(8'(8 * x + 4), 8'hC5);
      rc(8'(8 * x), 8'(x));
    end
    wr(ACS_ADDR_STAT, 8'h03);
    base = core.n_start;
    wr(ACS_ADDR_CTRL1, 8'h03);
    wt(1'b0, core.n_done + 8);
    wr(ACS_ADDR_CTRL1, 8'h00);
    for (int i = 0; i < 8; i++)
      chk({12'h0, core.ch_log[base + i]}, 16'(i % 3));
    rc(ACS_ADDR_STAT, 8'h03);
    chk({15'h0, conv_req.power_on}, 16'h0000);
    wr(ACS_ADDR_STAT, 8'h03);
    wr(ACS_ADDR_CTRL2, 8'h00);
    wr(ACS_ADDR_CSTS, 8'h05);
    wr(ACS_ADDR_CTRL1, 8'h01);
    wr(ACS_ADDR_CTRL1, 8'h03);
    wt(1'b0, core.n_done + 3);
    wr(ACS_ADDR_CTRL1, 8'h00);
    rc(ACS_ADDR_STAT, 8'h01);
    rc(ACS_ADDR_DHI, 8'h05);
    wr(ACS_ADDR_STAT, 8'h03);
    // Overrun interrupt masked so only the full buffer raises the line
    wr(ACS_ADDR_MASK, 8'h01);
    wr(ACS_ADDR_CTRL3, 8'h80);
    wr(ACS_ADDR_CTRL1, 8'h01);
    base = core.n_done;
    wr(ACS_ADDR_CTRL1, 8'h03);
    wt(1'b1, 0);
    chk(16'(core.n_done - base), 16'h000A);
    wr(ACS_ADDR_CTRL1, 8'h00);
    rc(ACS_ADDR_STAT, 8'h03);
    rc(ACS_ADDR_CTRL3, 8'hC0);
    wr(ACS_ADDR_STAT, 8'h03);
    wr(ACS_ADDR_CTRL3, 8'h00);
    wr(ACS_ADDR_CTRL1, 8'h01);
    foreach (codes[k]) begin
      base = core.n_start;
      wr(ACS_ADDR_CTRL2, codes[k]);
      @(posedge clk);
      tmr <= 1'b1;
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      tmr <= 1'b0;
      pin <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk(16'(core.n_start - base), {15'h0, codes[k] != 8'h60});
    end
    give_verdict();
  end
endmodule : adc_conversion_sequencer_tb
